// File: rtl/sci_defines.vh
// Purpose: constants of the serial client interface
// Assumes: 40 MHz system clock
// Notes:   times are kept in printed units, cycle counts derived
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH

// ==========================================================
// clock and timing
`define SCI_CLK_HZ        40000000
`define SCI_TIMEOUT_MS    30
`define SCI_IDLE_US       200
`define SCI_FSCL_MIN_KHZ  10
`define SCI_FSCL_MAX_KHZ  400
`define SCI_TIMEOUT_CYC   (`SCI_TIMEOUT_MS * (`SCI_CLK_HZ / 1000))
`define SCI_IDLE_CYC      (`SCI_IDLE_US * (`SCI_CLK_HZ / 1000000))

// ==========================================================
// link framing
`define SCI_DEV_ADDR      7'h28
`define SCI_BITS_PER_BYTE 4'h8
`define SCI_PTR_RESET     8'h00

`endif

// File: rtl/sci_sync.v
// Purpose: two-flop synchroniser with one delayed copy for edge finding
// Assumes: inputs are asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps

module sci_sync
#(
    parameter       WIDTH     = 2,
    parameter [1:0] RESET_VAL = 2'h3
)
(
    // clock and reset
    input  wire             clk,
    input  wire             rstn,
    // lines
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out,
    output reg  [WIDTH-1:0] sync_dly
);

    reg [WIDTH-1:0] meta;

    // ==========================================================
    // stages
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta     <= RESET_VAL[WIDTH-1:0];
            sync_out <= RESET_VAL[WIDTH-1:0];
            sync_dly <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
            sync_dly <= sync_out;
        end
    end

endmodule

// File: rtl/sci_client.v
// Purpose: two-wire serial client, address match, ack, register pointer
// Assumes: host is bus master; register file sits on the same clock
// Notes:   bus clock line is sampled, never driven
`timescale 1ns/100ps
`include "sci_defines.vh"

// What this block does
// - never drive the clock line low; tolerate stretched clocks from others.
// - start is data falling while clock high; recognised here.
// - first byte after start holds seven address bits then direction bit.
// - answer only to address 0101000, read or write.
// - bytes are eight bits, most significant bit first, both ways.
// - acknowledge every received byte by pulling data low on ninth clock.
// - stop condition resets client state, ready for a new transfer.
// - with timeout enabled, clock low for 30 ms resets the interface.
// - timeout is off after reset until software enables it.
// - with timeout enabled, both lines high over 200 us resets protocol.
// - clock from 10 kHz to 400 kHz must work.
// - multi-byte transfers carry no count byte; host ends them.
// - write byte stores one data byte at pointer register, all acked.
// - read byte sets pointer, repeated start, returns one byte.
// - pointer byte then stop only loads the pointer.
// - pointer-only write and pointer-less read may fail in deep sleep.
// - read without pointer returns the current register, repeatably.
// - multi-byte read advances pointer per host-acked byte, wrapping FFh to 00h.
// - multi-byte write advances pointer per byte, wrapping FFh to 00h.
module sci_client
#(
    parameter [31:0] TIMEOUT_CYC = `SCI_TIMEOUT_CYC,
    parameter [31:0] IDLE_CYC    = `SCI_IDLE_CYC,
    parameter [6:0]  DEV_ADDR    = `SCI_DEV_ADDR
)
(
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // serial link pins
    input  wire       bus_clock_line_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    // configuration levels
    input  wire       timeout_en,
    input  wire       deep_sleep_bit,
    // register file side
    output wire [7:0] reg_raddr,
    input  wire [7:0] reg_rdata,
    output reg        reg_rd,
    output reg  [7:0] reg_waddr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    // status
    output wire       busy,
    output reg        bus_reset
);

    // ==========================================================
    // states
    localparam [8:0] ST_IDLE  = 9'h001;
    localparam [8:0] ST_ADDR  = 9'h002;
    localparam [8:0] ST_ACK   = 9'h004;
    localparam [8:0] ST_PTR   = 9'h008;
    localparam [8:0] ST_WDATA = 9'h010;
    localparam [8:0] ST_RDATA = 9'h020;
    localparam [8:0] ST_HACK  = 9'h040;
    localparam [8:0] ST_IGN   = 9'h080;
    localparam [8:0] ST_WAIT  = 9'h100;

    // ==========================================================
    // declarations
    wire [1:0] lines_s;
    wire [1:0] lines_d;
    wire       scl_s;
    wire       sda_s;
    wire       scl_d;
    wire       sda_d;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire       timeout_hit;
    wire       idle_hit;
    wire       byte_end;
    wire       addr_hit;
    wire       last_rbit;
    wire [7:0] next_ptr;

    reg  [8:0]  state;
    reg  [8:0]  ack_next;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg  [7:0]  ptr;
    reg         sda_drive;
    reg         host_ack;
    reg  [31:0] low_cnt;
    reg  [31:0] idle_cnt;
    reg  [31:0] next_low_cnt;
    reg  [31:0] next_idle_cnt;

    // ==========================================================
    // line sampling
    sci_sync
    #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    )
    u_sync
    (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({bus_clock_line_in, sda_in}),
        .sync_out (lines_s),
        .sync_dly (lines_d)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];
    assign scl_d = lines_d[1];
    assign sda_d = lines_d[0];

    // sampling at 40 MHz keeps many samples per bit even at 400 kHz
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // pin drive
    // open drain: only the data line is ever pulled, clock is input only
    assign sda_out   = 1'b0;
    assign sda_oe    = sda_drive;
    assign reg_raddr = ptr;
    assign busy      = (state != ST_IDLE) && (state != ST_IGN);

    // ==========================================================
    // byte framing
    // a byte ends on the fall after its eighth rise; the ack owns the next low phase
    assign byte_end  = scl_fall && (bit_cnt == `SCI_BITS_PER_BYTE);
    assign addr_hit  = (shreg[7:1] == DEV_ADDR);
    assign last_rbit = (bit_cnt == `SCI_BITS_PER_BYTE - 4'h1);
    // eight-bit arithmetic, so FFh steps to 00h by itself
    assign next_ptr  = ptr + 8'h01;

    // ==========================================================
    // bus watchdogs
    // counters stay cleared while disabled, so enable starts fresh
    assign timeout_hit = timeout_en && (low_cnt == TIMEOUT_CYC - 32'h1);
    assign idle_hit    = timeout_en && (idle_cnt == IDLE_CYC);

    always @*
    begin
        next_low_cnt  = 32'h0;
        next_idle_cnt = 32'h0;
        if (timeout_en && !scl_s && !timeout_hit)
            next_low_cnt = low_cnt + 32'h1;
        if (timeout_en && scl_s && sda_s && !idle_hit)
            next_idle_cnt = idle_cnt + 32'h1;
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cnt  <= 32'h0;
            idle_cnt <= 32'h0;
        end
        else
        begin
            low_cnt  <= next_low_cnt;
            idle_cnt <= next_idle_cnt;
        end
    end

    // ==========================================================
    // protocol engine
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state     <= ST_IDLE;
            ack_next  <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            ptr       <= `SCI_PTR_RESET;
            sda_drive <= 1'b0;
            host_ack  <= 1'b0;
            reg_rd    <= 1'b0;
            reg_wr    <= 1'b0;
            reg_waddr <= 8'h00;
            reg_wdata <= 8'h00;
            bus_reset <= 1'b0;
        end
        else
        begin
            // strobes are single-cycle pulses unless a branch below raises them
            reg_rd    <= 1'b0;
            reg_wr    <= 1'b0;
            bus_reset <= 1'b0;
            if (stop_det)
            begin
                // pointer survives: it is what a later pointer-less read uses
                state     <= ST_IDLE;
                sda_drive <= 1'b0;
            end
            else if (timeout_hit || (idle_hit && state != ST_IDLE))
            begin
                state     <= ST_IDLE;
                sda_drive <= 1'b0;
                bus_reset <= 1'b1;
            end
            else if (start_det)
            begin
                // repeated start is handled the same as a first start
                state     <= ST_ADDR;
                bit_cnt   <= 4'h0;
                sda_drive <= 1'b0;
            end
            else
            begin
                case (state)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shreg   <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        bit_cnt <= 4'h0;
                        state   <= ST_ACK;
                        if (state == ST_ADDR)
                        begin
                            if (addr_hit)
                            begin
                                sda_drive <= 1'b1;
                                ack_next  <= shreg[0] ? ST_RDATA : ST_PTR;
                            end
                            else
                            begin
                                state <= ST_IGN;
                            end
                        end
                        else if (state == ST_PTR)
                        begin
                            // works in deep sleep too; hosts just may not rely on it
                            ptr       <= shreg;
                            sda_drive <= 1'b1;
                            ack_next  <= ST_WDATA;
                        end
                        else
                        begin
                            reg_wr    <= 1'b1;
                            reg_waddr <= ptr;
                            reg_wdata <= shreg;
                            ptr       <= next_ptr;
                            sda_drive <= 1'b1;
                            ack_next  <= ST_WDATA;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt <= 4'h0;
                        state   <= ack_next;
                        if (ack_next == ST_RDATA)
                        begin
                            // first bit goes out on the fall that ends the ack
                            shreg     <= reg_rdata;
                            sda_drive <= ~reg_rdata[7];
                            reg_rd    <= 1'b1;
                        end
                        else
                        begin
                            sda_drive <= 1'b0;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_rbit)
                        begin
                            sda_drive <= 1'b0;
                            state     <= ST_HACK;
                        end
                        else
                        begin
                            shreg     <= {shreg[6:0], 1'b0};
                            sda_drive <= ~shreg[6];
                        end
                    end
                end
                ST_HACK:
                begin
                    if (scl_rise)
                    begin
                        // advance only when the host asks for more bytes
                        host_ack <= ~sda_s;
                        if (!sda_s)
                            ptr <= next_ptr;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt <= 4'h0;
                        if (host_ack)
                        begin
                            shreg     <= reg_rdata;
                            sda_drive <= ~reg_rdata[7];
                            reg_rd    <= 1'b1;
                            state     <= ST_RDATA;
                        end
                        else
                        begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_IGN:
                begin
                    // another client's transfer: stay off the data line
                    sda_drive <= 1'b0;
                end
                ST_WAIT:
                begin
                    // host has sent its nack; only a start, a stop or a bus watchdog reset moves on
                    sda_drive <= 1'b0;
                end
                default:
                begin
                    sda_drive <= 1'b0;
                    state     <= ST_IDLE;
                end
                endcase
            end
        end
    end

endmodule

// File: dv/sci_client_asserts.sv
// Purpose: protocol checks on the serial client ports
// Assumes: one clock domain; pins watched raw, before the sync flops
// Notes:   raw counters run ahead of the design's by the sync lag
`timescale 1ns/100ps
module sci_client_asserts
#(
    parameter [31:0] TIMEOUT_CYC = 32'h3C,
    parameter [31:0] IDLE_CYC    = 32'h28
)
(
    // clock and reset
    input wire       clk,
    input wire       rstn,
    // link and levels
    input wire       bus_clock_line_in,
    input wire       sda_in,
    input wire       sda_oe,
    input wire       timeout_en,
    // register side and status
    input wire [7:0] reg_raddr,
    input wire       reg_rd,
    input wire [7:0] reg_waddr,
    input wire       reg_wr,
    input wire       busy,
    input wire       bus_reset
);
    // ==========================================
    // line-level run counters
    reg [31:0] low_cnt;
    reg [31:0] hi_cnt;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cnt <= 32'h0;
            hi_cnt  <= 32'h0;
        end
        else
        begin
            low_cnt <= bus_clock_line_in ? 32'h0 : low_cnt + 32'h1;
            hi_cnt  <= (bus_clock_line_in && sda_in) ? hi_cnt + 32'h1 : 32'h0;
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_pulse; reg_rd |=> !reg_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_wr_step; reg_wr |-> ##[0:2] (reg_raddr == reg_waddr + 8'h01); endproperty
    a_wr_step: assert property (p_wr_step) else $error("pointer did not step");
    property p_waddr_hold; $changed(reg_waddr) |-> reg_wr; endproperty
    a_waddr_hold: assert property (p_waddr_hold) else $error("write address moved");
    property p_stop_idle; $rose(sda_in) && bus_clock_line_in |-> ##[1:6] !busy; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");
    // data may only move while the clock is low, or it forms a start/stop
    property p_oe_scl_low; $changed(sda_oe) |-> !$past(bus_clock_line_in); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
    property p_oe_owner; sda_oe |-> busy || $past(busy); endproperty
    a_oe_owner: assert property (p_oe_owner) else $error("data driven while idle");
    property p_rst_enabled; bus_reset |-> $past(timeout_en); endproperty
    a_rst_enabled: assert property (p_rst_enabled) else $error("reset while disabled");
    property p_rst_cause; bus_reset |-> low_cnt >= TIMEOUT_CYC || hi_cnt >= IDLE_CYC; endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("early bus reset");
    property p_to_bound; timeout_en && low_cnt > TIMEOUT_CYC + 32'h8 |-> !busy; endproperty
    a_to_bound: assert property (p_to_bound) else $error("clock-low timeout missed");
    property p_idle_bound; timeout_en && hi_cnt > IDLE_CYC + 32'h8 |-> !busy; endproperty
    a_idle_bound: assert property (p_idle_bound) else $error("idle reset missed");
    c_write: cover property (reg_wr);
    c_read: cover property (reg_rd);
    c_ack: cover property ($rose(sda_oe));
    c_bus_reset: cover property (bus_reset);
endmodule

bind sci_client sci_client_asserts
#(
    .TIMEOUT_CYC (TIMEOUT_CYC),
    .IDLE_CYC    (IDLE_CYC)
)
u_asserts
(
    .clk(clk), .rstn(rstn), .bus_clock_line_in(bus_clock_line_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .timeout_en(timeout_en), .reg_raddr(reg_raddr), .reg_rd(reg_rd),
    .reg_waddr(reg_waddr), .reg_wr(reg_wr), .busy(busy), .bus_reset(bus_reset)
);

// File: dv/sci_host.sv
// Purpose: bus master model driving the clock and data lines
// Assumes: pull-ups on both lines; this host never stretches
// Notes:   200 ns bit time, all changes at the falling clk edge
`timescale 1ns/100ps
module sci_host
(
    // clock
    input  wire  clk,
    // link
    input  wire  sda,
    output logic scl,
    output logic sda_low
);
    // ==========================================
    // bit and byte level
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task start();
        sda_low = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl = 1'b0;
        wt(2);
    endtask
    // data set mid-low, sampled mid-high, clear of the device's lag
    task bit_io(input logic b, output logic r);
        sda_low = !b;
        wt(2);
        scl = 1'b1;
        wt(2);
        r = sda;
        wt(2);
        scl = 1'b0;
        wt(2);
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
    task stop();
        sda_low = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_low = 1'b0;
        wt(4);
    endtask
    // both lines left high, for the idle reset
    task idle(input int n);
        sda_low = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(n);
    endtask
endmodule

// File: dv/sci_client_test.sv
// Purpose: self-checking bench of the serial client
// Assumes: counts of 60 and 40 stand in for 30 ms and 200 us
// Notes:   register file modelled here, preloaded with its own index
`timescale 1ns/100ps
module sci_client_test;
    // ==========================================
    // signals
    localparam [31:0] TO_CYC = 32'h3C;
    localparam [31:0] ID_CYC = 32'h28;
    logic        clk;
    logic        rstn;
    logic        timeout_en;
    logic        deep_sleep_bit;
    logic        scl;
    logic        host_low;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic        reg_rd;
    logic        reg_wr;
    logic        busy;
    logic        bus_reset;
    logic        ack;
    logic [7:0]  reg_raddr;
    logic [7:0]  reg_rdata;
    logic [7:0]  reg_waddr;
    logic [7:0]  reg_wdata;
    logic [7:0]  mem [0:255];
    logic [7:0]  rq [0:3];
    logic [31:0] mismatches;
    logic [31:0] cmp_count;
    logic [31:0] wr_cnt;
    logic [31:0] rst_cnt;
    logic [31:0] rd_cnt;
    logic [31:0] w0;
    logic [31:0] r0;
    // ==========================================
    // wiring, register file, clock
    assign sda = !(host_low || (sda_oe && !sda_out));
    assign reg_rdata = mem[reg_raddr];
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (reg_wr === 1'b1)
        begin
            mem[reg_waddr] <= reg_wdata;
            wr_cnt <= wr_cnt + 1;
        end
        if (bus_reset === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (reg_rd === 1'b1)
            rd_cnt <= rd_cnt + 1;
    end
    sci_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
    sci_client
    #(
        .TIMEOUT_CYC (TO_CYC),
        .IDLE_CYC    (ID_CYC)
    )
    u_dut
    (
        .clk(clk), .rstn(rstn), .bus_clock_line_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .timeout_en(timeout_en), .deep_sleep_bit(deep_sleep_bit),
        .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .busy(busy), .bus_reset(bus_reset)
    );
    // ==========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task hw(input logic [7:0] ptr, input int n, input logic [7:0] base);
        u_host.start();
        u_host.wbyte(8'h50, ack);
        chk(ack, 1);
        u_host.wbyte(ptr, ack);
        chk(ack, 1);
        for (int i = 0; i < n; i++)
        begin
            u_host.wbyte(base + 8'(i * 17), ack);
            chk(ack, 1);
        end
        u_host.stop();
    endtask
    task hr(input logic [7:0] ptr, input logic setp, input int n);
        if (setp)
        begin
            u_host.start();
            u_host.wbyte(8'h50, ack);
            u_host.wbyte(ptr, ack);
            chk(ack, 1);
        end
        u_host.start();
        u_host.wbyte(8'h51, ack);
        chk(ack, 1);
        for (int i = 0; i < n; i++)
            u_host.rbyte(i == n - 1, rq[i]);
        u_host.stop();
    endtask
    // ==========================================
    // scenarios
    task t_single();
        w0 = wr_cnt;
        hw(8'h10, 1, 8'hC4);
        chk(mem[8'h10], 8'hC4);
        chk(wr_cnt - w0, 1);
        chk(busy, 0);
        r0 = rd_cnt;
        hr(8'h10, 1, 1);
        chk(rq[0], 8'hC4);
        chk(rd_cnt - r0, 1);
    endtask
    task t_short();
        w0 = wr_cnt;
        hw(8'h42, 0, 8'h00);
        chk(wr_cnt - w0, 0);
        hr(8'h00, 0, 1);
        chk(rq[0], 8'h42);
        deep_sleep_bit = 1'b1;
        hr(8'h00, 0, 1);
        chk(rq[0], 8'h42);
        deep_sleep_bit = 1'b0;
    endtask
    // bit-reversed own address must not be mistaken for it
    task t_wrong();
        w0 = wr_cnt;
        u_host.start();
        u_host.wbyte(8'h14, ack);
        chk(ack, 0);
        u_host.wbyte(8'h10, ack);
        chk(ack, 0);
        chk(busy, 0);
        u_host.stop();
        chk(wr_cnt - w0, 0);
    endtask
    task t_timeout();
        r0 = rst_cnt;
        u_host.start();
        u_host.wbyte(8'h50, ack);
        u_host.wt(100);
        chk(rst_cnt - r0, 0);
        chk(busy, 1);
        u_host.stop();
        timeout_en = 1'b1;
        u_host.start();
        u_host.wbyte(8'h50, ack);
        u_host.wt(100);
        chk(rst_cnt - r0, 1);
        chk(busy, 0);
        u_host.idle(4);
        u_host.start();
        u_host.wbyte(8'h50, ack);
        u_host.idle(100);
        chk(rst_cnt - r0, 2);
        chk(busy, 0);
        timeout_en = 1'b0;
    endtask
    task t_block();
        hw(8'hFE, 3, 8'h11);
        chk(mem[8'hFE], 8'h11);
        chk(mem[8'hFF], 8'h22);
        chk(mem[8'h00], 8'h33);
        r0 = rd_cnt;
        hr(8'hFF, 1, 3);
        chk(rd_cnt - r0, 3);
        chk(rq[0], 8'h22);
        chk(rq[1], 8'h33);
        chk(rq[2], 8'h01);
        hr(8'h00, 0, 1);
        chk(rq[0], 8'h01);
    endtask
    task results();
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count != 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        {clk, rstn, timeout_en, deep_sleep_bit} = 4'h0;
        {mismatches, cmp_count, wr_cnt, rst_cnt, rd_cnt} = 160'h0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i);
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        u_host.wt(4);
        chk(reg_raddr, 8'h00);
        t_single();
        t_short();
        t_wrong();
        t_timeout();
        t_block();
        results();
    end
    // roughly fourteen times the expected run length
    initial
    begin
        #1000000;
        mismatches = mismatches + 1;
        results();
    end
endmodule
